// File: rtl/pulse_bridge_pkg.sv
// Purpose: Shared constants and carriers for the isolated SPI pulse bridge control.
// Assumes: 50 MHz clock.
// Notes: Pulse halves are in line clock cycles.
package pulse_bridge_pkg;

  localparam int CLK_MHZ = 50;
  localparam int IDLE_TIME_US = 5700;
  localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
  localparam int WAKE_TIME_NS = 8000;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS * CLK_MHZ) / 1000;
  localparam int LONG_HALF_NS = 150;
  localparam int LONG_HALF_CYCLES = (LONG_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int SHORT_HALF_NS = 50;
  localparam int SHORT_HALF_CYCLES = (SHORT_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int SCK_PULSE_NS = 120;
  localparam int SCK_PULSE_CYCLES = (SCK_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOW_FACTOR = 8;
  localparam int RETURN_WAIT_CYCLES = 2;

  typedef struct packed {
    logic roleMaster;
    logic slowTiming;
    logic clockPolarity;
    logic clockPhase;
    logic stayAwake;
  } strap_s;

  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } pin_s;

endpackage : pulse_bridge_pkg

// File: rtl/pulse_bridge_ctrl.sv
// Purpose: Role, pin direction, pulse coding and idle control of an isolated SPI pulse bridge.
// Assumes: All pins asynchronous; two-stage synchronised before use. Line pair is two drive/sense bits.
// Notes: Summary of operation
`timescale 1ns/100ps
module pulse_bridge_ctrl
  import pulse_bridge_pkg::*;
#(
  parameter int IDLE_COUNT = IDLE_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire strap_s straps,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic csIn,
  output logic csOut,
  output logic csOe,
  input wire logic linePlusIn,
  input wire logic lineMinusIn,
  output logic linePlusOut,
  output logic lineMinusOut,
  output logic lineOe,
  output logic awake
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAKE = 3'b001,
    ST_RUN = 3'b010,
    ST_TX1 = 3'b011,
    ST_TX2 = 3'b100
  } power_e;

  // Two-flop synchronisers for every pin input
  logic [10:0] syncA_q, syncB_q;
  wire logic [10:0] rawIn = {straps, mosiIn, misoIn, sckIn, csIn, linePlusIn, lineMinusIn};
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      syncA_q <= 11'h7FF;
      syncB_q <= 11'h7FF;
    end
    else
    begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
    end
  end

  wire logic isMaster = syncB_q[10];
  wire logic slowSel = syncB_q[9];
  wire logic polSel = syncB_q[8];
  wire logic phaSel = syncB_q[7];
  wire logic stayOn = syncB_q[6];
  wire logic mosiS = syncB_q[5];
  wire logic misoS = syncB_q[4];
  wire logic sckS = syncB_q[3];
  wire logic csS = syncB_q[2];
  wire logic lpS = syncB_q[1];
  wire logic lmS = syncB_q[0];

  logic sckPrev_q, csPrev_q;
  wire logic sckRise = sckS & ~sckPrev_q;
  wire logic sckFall = ~sckS & sckPrev_q;
  // Latching edge: first edge when phase is 0, second when 1; polarity inverts
  wire logic latchOnRise = polSel ~^ phaSel;
  wire logic latchEdge = latchOnRise ? sckRise : sckFall;
  wire logic shiftEdge = latchOnRise ? sckFall : sckRise;
  wire logic csRise = csS & ~csPrev_q;
  wire logic csFall = ~csS & csPrev_q;
  wire logic lineActive = lpS ^ lmS;

  // Transmit encoder: polarity, half length, busy
  logic txBusy_q, txSecond_q, txPlus_q;
  logic [15:0] txCnt_q, halfLen_q;
  logic [1:0] rxPrevLvl_q;
  logic [15:0] rxLen_q;
  logic [1:0] rxFirst_q;

  // Power state and timers
  power_e power_q;
  logic [31:0] idleCnt_q;
  logic [15:0] wakeCnt_q;

  wire logic isAwake = (power_q == ST_RUN);
  wire logic [15:0] slowMul = slowSel ? 16'(SLOW_FACTOR) : 16'h0001;
  wire logic [15:0] longHalf = 16'(LONG_HALF_CYCLES);
  wire logic [15:0] shortHalf = 16'(SHORT_HALF_CYCLES);
  wire logic idleCause = isMaster ? csS : ~lineActive;
  wire logic wakeCause = isMaster ? csFall : lineActive;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      power_q <= ST_WAKE;
      idleCnt_q <= 32'h0000_0000;
      wakeCnt_q <= 16'h0000;
    end
    else
    begin
      case (power_q)
        ST_IDLE:
        begin
          wakeCnt_q <= 16'h0000;
          if (wakeCause || stayOn)
            power_q <= ST_WAKE;
        end
        ST_WAKE:
        begin
          wakeCnt_q <= wakeCnt_q + 16'h0001;
          if (wakeCnt_q >= 16'(WAKE_CYCLES - 1) || wakeCnt_q >= 16'h0003)
            power_q <= ST_RUN;
        end
        ST_RUN:
        begin
          if (stayOn || !idleCause || txBusy_q)
            idleCnt_q <= 32'h0000_0000;
          else if (idleCnt_q >= 32'(IDLE_COUNT - 1))
          begin
            idleCnt_q <= 32'h0000_0000;
            power_q <= ST_IDLE;
          end
          else
            idleCnt_q <= idleCnt_q + 32'h0000_0001;
        end
        default: power_q <= ST_WAKE;
      endcase
    end
  end

  // Decode received pulse pairs: measure first half length and polarity
  wire logic [1:0] rxLvl = {lpS & ~lmS, lmS & ~lpS};
  wire logic rxHalfEnd = (rxLvl != rxPrevLvl_q) && (rxPrevLvl_q != 2'b00);
  wire logic rxPairDone = rxHalfEnd && (rxFirst_q != 2'b00) && (rxLvl == 2'b00);
  wire logic rxPlus = rxFirst_q == 2'b10;

  logic [15:0] rxHalf_q;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rxPrevLvl_q <= 2'b00;
      rxLen_q <= 16'h0000;
      rxHalf_q <= 16'h0000;
      rxFirst_q <= 2'b00;
    end
    else
    begin
      rxPrevLvl_q <= rxLvl;
      if (rxLvl != rxPrevLvl_q)
        rxLen_q <= 16'h0001;
      else if (rxLen_q != 16'hFFFF)
        rxLen_q <= rxLen_q + 16'h0001;
      if (rxHalfEnd && rxFirst_q == 2'b00)
      begin
        rxFirst_q <= rxPrevLvl_q;
        rxHalf_q <= rxLen_q;
      end
      else if (rxPairDone || (rxLvl == 2'b00 && rxPrevLvl_q == 2'b00))
        rxFirst_q <= 2'b00;
    end
  end
  wire logic rxIsLong = rxHalf_q >= 16'((LONG_HALF_CYCLES * 2) / 3);

  // Transmit request decode
  wire logic masterLongReq = isMaster && isAwake && (csRise || csFall);
  wire logic masterShortReq = isMaster && isAwake && latchEdge && !csS;
  logic retPending_q;
  wire logic slaveRetReq = !isMaster && retPending_q && !misoS;
  wire logic txStart = !txBusy_q && (masterLongReq || masterShortReq || slaveRetReq);
  wire logic startPlus = masterLongReq ? csRise : (masterShortReq ? mosiS : 1'b0);
  wire logic [15:0] startHalf = (masterLongReq ? longHalf : shortHalf) * slowMul;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      txBusy_q <= 1'b0;
      txSecond_q <= 1'b0;
      txPlus_q <= 1'b0;
      txCnt_q <= 16'h0000;
      halfLen_q <= 16'h0000;
    end
    else if (txStart)
    begin
      txBusy_q <= 1'b1;
      txSecond_q <= 1'b0;
      txPlus_q <= startPlus;
      halfLen_q <= startHalf;
      txCnt_q <= 16'h0001;
    end
    else if (txBusy_q)
    begin
      if (txCnt_q >= halfLen_q)
      begin
        txCnt_q <= 16'h0001;
        txSecond_q <= 1'b1;
        if (txSecond_q)
          txBusy_q <= 1'b0;
      end
      else
        txCnt_q <= txCnt_q + 16'h0001;
    end
  end

  // Slave side reconstruction and master MISO return tracking
  logic csDrv_q, mosiDrv_q, sckDrv_q, misoDrv_q;
  logic [15:0] sckCnt_q;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      csDrv_q <= 1'b1;
      mosiDrv_q <= 1'b1;
      sckDrv_q <= 1'b0;
      sckCnt_q <= 16'h0000;
      retPending_q <= 1'b0;
      misoDrv_q <= 1'b1;
    end
    else
    begin
      if (!sckCnt_q[15] && sckCnt_q != 16'h0000)
        sckCnt_q <= sckCnt_q - 16'h0001;
      // Clock leaves its idle level one cycle after MOSI is set, so the slave sees settled data
      if (sckCnt_q == 16'(SCK_PULSE_CYCLES) * slowMul + 16'h0001)
        sckDrv_q <= ~polSel;
      if (sckCnt_q == 16'h0001)
      begin
        sckDrv_q <= polSel;
        retPending_q <= 1'b1;
      end
      if (txStart && slaveRetReq)
        retPending_q <= 1'b0;
      else if (!isMaster && retPending_q && misoS)
        retPending_q <= 1'b0;
      if (!isMaster && rxPairDone)
      begin
        if (rxIsLong)
          csDrv_q <= rxPlus;
        else
        begin
          mosiDrv_q <= rxPlus;
          sckCnt_q <= 16'(SCK_PULSE_CYCLES) * slowMul + 16'h0001;
        end
      end
      if (isMaster)
      begin
        if (shiftEdge || csS)
          misoDrv_q <= 1'b1;
        if (rxPairDone && !rxIsLong && !rxPlus)
          misoDrv_q <= 1'b0;
      end
      else
        misoDrv_q <= 1'b1;
      if (isMaster)
        sckDrv_q <= polSel;
    end
  end

  // Output registers; pin directions follow the role strap
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sckPrev_q <= 1'b0;
      csPrev_q <= 1'b1;
      mosiOut <= 1'b0;
      mosiOe <= 1'b0;
      misoOut <= 1'b0;
      misoOe <= 1'b0;
      sckOut <= 1'b0;
      sckOe <= 1'b0;
      csOut <= 1'b1;
      csOe <= 1'b0;
      linePlusOut <= 1'b0;
      lineMinusOut <= 1'b0;
      lineOe <= 1'b0;
      awake <= 1'b0;
    end
    else
    begin
      sckPrev_q <= sckS;
      csPrev_q <= csS;
      mosiOut <= 1'b0;
      mosiOe <= !isMaster && !mosiDrv_q;
      misoOut <= 1'b0;
      misoOe <= isMaster && !misoDrv_q;
      sckOut <= sckDrv_q;
      sckOe <= !isMaster;
      csOut <= csDrv_q;
      csOe <= !isMaster;
      linePlusOut <= txBusy_q && (txPlus_q ^ txSecond_q);
      lineMinusOut <= txBusy_q && !(txPlus_q ^ txSecond_q);
      lineOe <= txBusy_q;
      awake <= isAwake;
    end
  end

  a_stay_awake: assert property (@(posedge clk) disable iff (reset)
    stayOn && isAwake |=> isAwake) else $error("idle entered while stay-awake high");

  a_slave_no_long: assert property (@(posedge clk) disable iff (reset)
    txStart && !isMaster |-> startHalf == shortHalf * slowMul && !startPlus)
    else $error("slave started a long or positive pulse");

  sequence s_wake_start;
    power_q == ST_IDLE ##1 power_q == ST_WAKE;
  endsequence

  a_wake_time: assert property (@(posedge clk) disable iff (reset)
    s_wake_start |-> ##[1:8] isAwake) else $error("wake took too long");

  a_master_pins_in: assert property (@(posedge clk) disable iff (reset)
    isMaster |=> !mosiOe && !sckOe && !csOe) else $error("master role drove an input pin");

  a_slave_miso_in: assert property (@(posedge clk) disable iff (reset)
    !isMaster |=> !misoOe) else $error("slave role drove MISO");

  a_pulse_half_load: assert property (@(posedge clk) disable iff (reset)
    txStart |=> txBusy_q && txCnt_q == 16'h0001 && halfLen_q == $past(startHalf))
    else $error("pulse half length not loaded");

endmodule : pulse_bridge_ctrl

// File: dv/spi_slave_model.sv
// Purpose: SPI slave that sits behind the bridge in slave role.
// Assumes: Mode 0 straps; MISO is open drain with a pull-up in the bench.
// Notes: Reply level is commanded by the bench.
`timescale 1ns/100ps
module spi_slave_model
(
  input wire logic cs,
  input wire logic sck,
  input wire logic mosi,
  input wire logic replyBit,
  output logic misoLow,
  output logic lastMosi
);
  // Only ever pulls MISO low, while selected
  assign misoLow = !cs && !replyBit;
  initial lastMosi = 1'b0;
  // Mode 0 latches on the rising clock edge
  always @(posedge sck)
  begin
    lastMosi <= mosi;
  end
endmodule : spi_slave_model

// File: dv/isolated_spi_pulse_bridge_control_test.sv
// Purpose: Self-checking bench for the pulse bridge control, both roles.
// Assumes: Idle count shortened to 50 cycles; straps mode 0, fast timing.
// Notes: Line pulses are driven and watched by the bench itself.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
`define WAITV(s, v, l) for (w = 0; w < l && s !== v; w++) begin @(posedge clk); #1; end
module isolated_spi_pulse_bridge_control_test;
  import pulse_bridge_pkg::*;
  localparam int IDLE = 50;
  logic clk = 1'b0;
  logic reset = 1'b1;
  strap_s straps = '0;
  logic mosiDrv = 1'b1, sckDrv = 1'b0, csDrv = 1'b1, replyBit = 1'b1;
  logic linePlusIn = 1'b0, lineMinusIn = 1'b0;
  logic mosiOut, mosiOe, misoOut, misoOe, sckOut, sckOe, csOut, csOe;
  logic linePlusOut, lineMinusOut, lineOe, awake, misoLow, lastMosi;
  logic mosiIn, misoIn, sckIn, csIn;
  int mismatches = 0, n_tests = 0, w, n;
  always #10 clk = !clk;
  // Pin levels picked by role from the driving party; MOSI and MISO resolved from enables with pull-ups
  assign mosiIn = straps.roleMaster ? mosiDrv : !mosiOe;
  assign misoIn = !(misoOe || (!straps.roleMaster && misoLow));
  assign sckIn = straps.roleMaster ? sckDrv : sckOut;
  assign csIn = straps.roleMaster ? csDrv : csOut;
  pulse_bridge_ctrl #(.IDLE_COUNT(IDLE)) i_pulse_bridge_ctrl (.clk(clk), .reset(reset), .straps(straps),
    .mosiIn(mosiIn), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoIn), .misoOut(misoOut),
    .misoOe(misoOe), .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .csIn(csIn), .csOut(csOut),
    .csOe(csOe), .linePlusIn(linePlusIn), .lineMinusIn(lineMinusIn), .linePlusOut(linePlusOut),
    .lineMinusOut(lineMinusOut), .lineOe(lineOe), .awake(awake));
  spi_slave_model i_spi_slave_model (.cs(csOut), .sck(sckOut), .mosi(mosiIn), .replyBit(replyBit),
    .misoLow(misoLow), .lastMosi(lastMosi));
  task do_reset(input logic role);
    @(posedge clk);
    reset <= 1'b1;
    straps <= '{roleMaster: role, default: 1'b0};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    `WAITV(awake, 1'b1, 20)
    #1;
  endtask : do_reset
  // Checks polarity and length of each half of one pulse pair
  task expect_pulse(input logic sgn, input int half);
    `WAITV(lineOe, 1'b1, 60)
    #1;
    `CHK("first half plus", sgn, linePlusOut)
    `CHK("first half minus", !sgn, lineMinusOut)
    n = 0;
    while (lineOe === 1'b1 && linePlusOut === sgn && n < 40)
    begin
      n++;
      @(posedge clk);
      #1;
    end
    `CHK("first half length", half, n)
    n = 0;
    while (lineOe === 1'b1 && linePlusOut === !sgn && n < 40)
    begin
      n++;
      @(posedge clk);
      #1;
    end
    `CHK("second half length", half, n)
  endtask : expect_pulse
  task send_pulse(input logic sgn, input int half);
    @(posedge clk);
    linePlusIn <= sgn;
    lineMinusIn <= !sgn;
    repeat (half) @(posedge clk);
    linePlusIn <= !sgn;
    lineMinusIn <= sgn;
    repeat (half) @(posedge clk);
    linePlusIn <= 1'b0;
    lineMinusIn <= 1'b0;
  endtask : send_pulse
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial
  begin
    #400000;
    mismatches++;
    give_verdict;
  end
  initial
  begin
    do_reset(1'b1);
    `CHK("master mosiOe", 1'b0, mosiOe)
    `CHK("master sckOe", 1'b0, sckOe)
    `CHK("master csOe", 1'b0, csOe)
    `CHK("master misoOe", 1'b0, misoOe)
    @(posedge clk);
    csDrv <= 1'b0;
    expect_pulse(1'b0, LONG_HALF_CYCLES);
    for (int b = 0; b < 3; b++)
    begin
      @(posedge clk);
      mosiDrv <= (b != 0);
      repeat (3) @(posedge clk);
      sckDrv <= 1'b1;
      expect_pulse(b != 0, SHORT_HALF_CYCLES);
      if (b == 2)
      begin
        send_pulse(1'b0, SHORT_HALF_CYCLES);
        `WAITV(misoOe, 1'b1, 20)
        `CHK("miso pulled by return", 1'b1, misoOe)
      end
      @(posedge clk);
      sckDrv <= 1'b0;
      repeat (6) @(posedge clk);
    end
    csDrv <= 1'b1;
    expect_pulse(1'b1, LONG_HALF_CYCLES);
    @(posedge clk);
    straps.stayAwake <= 1'b1;
    repeat (3 * IDLE) @(posedge clk);
    `CHK("stay awake", 1'b1, awake)
    straps.stayAwake <= 1'b0;
    `WAITV(awake, 1'b0, IDLE + 20)
    `CHK("master idle", 1'b0, awake)
    @(posedge clk);
    csDrv <= 1'b0;
    `WAITV(awake, 1'b1, WAKE_CYCLES)
    `CHK("master wake", 1'b1, awake)
    $display("test master done");
    repeat (30) @(posedge clk);
    csDrv <= 1'b1;
    do_reset(1'b0);
    `CHK("slave sckOe", 1'b1, sckOe)
    `CHK("slave csOe", 1'b1, csOe)
    `CHK("slave mosiOut", 1'b0, mosiOut)
    send_pulse(1'b0, LONG_HALF_CYCLES);
    `WAITV(csOut, 1'b0, 20)
    `CHK("slave cs low", 1'b0, csOut)
    replyBit <= 1'b0;
    send_pulse(1'b1, SHORT_HALF_CYCLES);
    `WAITV(sckOut, 1'b1, 30)
    `CHK("slave sck pulse", 1'b1, sckOut)
    expect_pulse(1'b0, SHORT_HALF_CYCLES);
    `CHK("slave mosi one", 1'b1, lastMosi)
    replyBit <= 1'b1;
    send_pulse(1'b0, SHORT_HALF_CYCLES);
    `WAITV(lineOe, 1'b1, 40)
    `CHK("no return for one", 1'b0, lineOe)
    `CHK("slave mosi zero", 1'b0, lastMosi)
    send_pulse(1'b1, LONG_HALF_CYCLES);
    `WAITV(csOut, 1'b1, 20)
    `CHK("slave cs high", 1'b1, csOut)
    `CHK("no long return", 1'b0, lineOe)
    repeat (IDLE - 20) @(posedge clk);
    `CHK("slave not yet idle", 1'b1, awake)
    `WAITV(awake, 1'b0, 40)
    `CHK("slave idle", 1'b0, awake)
    send_pulse(1'b0, LONG_HALF_CYCLES);
    `WAITV(awake, 1'b1, WAKE_CYCLES)
    `CHK("slave wake", 1'b1, awake)
    $display("test slave done");
    give_verdict;
  end
endmodule : isolated_spi_pulse_bridge_control_test
